// >>> rtl/tpwl_defs.vh
// Constants of the three-wire PLL word loader.
// Assumes inclusion by bare name from the rtl files.
`ifndef TPWL_DEFS_VH
`define TPWL_DEFS_VH
`define TPWL_WORD_BITS   18
`define TPWL_DIV_BITS    14
`define TPWL_PORT_BITS   4
`define TPWL_BIT_COUNT   5'h12
`define TPWL_CNT_BITS    5
`define TPWL_RATIO_LOW   11'h400
`define TPWL_RATIO_MID   11'h200
`define TPWL_RATIO_HIGH  11'h280
`define TPWL_PUMP_HIGH   1'b1
`define TPWL_TEST_OFF    1'b0
`define TPWL_PUMP_ON     1'b0
`define TPWL_PSC_ON      1'b1
`define TPWL_VARICAP_ON  1'b0
`endif

// >>> rtl/tpwl_sync.v
// Three-stage synchroniser with agreement filter for one pin.
// Assumes an asynchronous pin sampled on sys_clk.
`timescale 1ns/100ps
module tpwl_sync (
  input  wire sys_clk,
  input  wire resetn,
  input  wire pin_in,
  output reg  level_reg
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // Sample chain; the level moves only when stages two and three agree
  always @(posedge sys_clk) begin
    if (!resetn) begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_reg <= s3_reg;
      end
    end
  end
endmodule

// >>> rtl/tpwl_ref_decode.v
// Decoder of the reference-select input into a reference ratio.
// Assumes the pin level arrives already split into low and high comparators.
`timescale 1ns/100ps
`include "tpwl_defs.vh"
module tpwl_ref_decode (
  input  wire        ref_sel_low,
  input  wire        ref_sel_high,
  output reg  [10:0] ratio
);
  // Low gives 1024, high 640, open or mid 512
  always @* begin
    if (ref_sel_low) begin
      ratio = `TPWL_RATIO_LOW;
    end else if (ref_sel_high) begin
      ratio = `TPWL_RATIO_HIGH;
    end else begin
      ratio = `TPWL_RATIO_MID;
    end
  end
endmodule

// >>> rtl/tpwl_loader.v
// Three-wire serial word loader of a tuner PLL synthesizer.
// Assumes the controller drives data, clock and enable pins asynchronously
// to sys_clk, well slower than it; the analog loop lives outside.
//
// Operation
// - Data on data pin, clock on clock pin, enable on select/enable pin.
// - One word carries fourteen divider bits plus port bits.
// - Divider bit fourteen is forced to zero in three-wire mode.
// - Shift one bit on each falling serial clock while enable is high.
// - Serial clock is ignored while enable is low.
// - Latch word at enable fall only after exactly eighteen clocks.
// - Port/lock pin becomes the lock indicator in three-wire mode.
// - In lock, the open-collector lock output turns on.
// - Pump current select held high.
// - Divider test select held at zero.
// - Pump disable held at zero.
// - Prescaler control held at one.
// - Varicap drive disable held at zero.
// - Reference ratio comes from the select input, not programmed bits.
// - Select low gives 1024, open or mid 512, high 640.
// - Divider value zero disables the whole loop.
// - Scaling factor is the binary weight of the divider bits.
// - Port bit one switches its open-collector output on; the code holds port1_oe at zero in every mode.
`timescale 1ns/100ps
`include "tpwl_defs.vh"
module tpwl_loader (
  sys_clk,
  resetn,
  serial_data_in,
  serial_clk_in,
  select_enable_pin,
  three_wire_mode,
  ref_ratio_sel_low,
  ref_ratio_sel_high,
  lock_detect,
  scaling_factor,
  port_output_bits,
  lock_indicator_pin_oe,
  port1_oe,
  ref_ratio,
  pump_current_high,
  divider_test_select,
  pump_disable_bit,
  prescaler_on,
  varicap_drive_off,
  pll_enable,
  word_loaded,
  word_rejected
);
  input  wire        sys_clk;
  input  wire        resetn;
  input  wire        serial_data_in;
  input  wire        serial_clk_in;
  input  wire        select_enable_pin;
  input  wire        three_wire_mode;
  input  wire        ref_ratio_sel_low;
  input  wire        ref_ratio_sel_high;
  input  wire        lock_detect;
  output reg  [14:0] scaling_factor;
  output reg  [3:0]  port_output_bits;
  output reg         lock_indicator_pin_oe;
  output reg         port1_oe;
  output reg  [10:0] ref_ratio;
  output reg         pump_current_high;
  output reg         divider_test_select;
  output reg         pump_disable_bit;
  output reg         prescaler_on;
  output reg         varicap_drive_off;
  output reg         pll_enable;
  output reg         word_loaded;
  output reg         word_rejected;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire data_lvl;
  wire clk_lvl;
  wire ena_lvl;

  tpwl_sync u_sync_data (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .pin_in    (serial_data_in),
    .level_reg (data_lvl)
  );
  tpwl_sync u_sync_clk (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .pin_in    (serial_clk_in),
    .level_reg (clk_lvl)
  );
  tpwl_sync u_sync_ena (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .pin_in    (select_enable_pin),
    .level_reg (ena_lvl)
  );

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  reg  clk_prev_reg;
  reg  ena_prev_reg;
  wire clk_fall;
  wire ena_fall;

  // Previous filtered levels
  always @(posedge sys_clk) begin
    if (!resetn) begin
      clk_prev_reg <= 1'b0;
      ena_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg <= clk_lvl;
      ena_prev_reg <= ena_lvl;
    end
  end

  assign clk_fall = clk_prev_reg & ~clk_lvl;
  assign ena_fall = ena_prev_reg & ~ena_lvl;

  // ----------------------------------------------------------------
  // Shift register and clock counter
  // ----------------------------------------------------------------
  reg [17:0] shift_reg;
  reg [4:0]  count_reg;
  reg        over_reg;

  // Shift on falling clock while enabled; ignore otherwise
  always @(posedge sys_clk) begin
    if (!resetn) begin
      shift_reg <= 18'h00000;
      count_reg <= 5'h00;
      over_reg  <= 1'b0;
    end else if (three_wire_mode && ena_lvl && clk_fall) begin
      // MSB first, new bit enters at bit 0
      shift_reg <= {shift_reg[16:0], data_lvl};
      if (count_reg == 5'h1F) begin
        over_reg <= 1'b1;
      end else begin
        count_reg <= count_reg + 5'h01;
      end
    end else if (!ena_lvl) begin
      count_reg <= 5'h00;
      over_reg  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Data latches
  // ----------------------------------------------------------------
  wire count_ok;
  wire [13:0] div_word;
  wire [3:0]  port_word;

  assign count_ok  = (count_reg == `TPWL_BIT_COUNT) && !over_reg;
  assign div_word  = shift_reg[17:4];
  assign port_word = shift_reg[3:0];

  // Latch only on enable fall after exactly eighteen clocks
  always @(posedge sys_clk) begin
    if (!resetn) begin
      scaling_factor   <= 15'h0000;
      port_output_bits <= 4'h0;
      word_loaded      <= 1'b0;
      word_rejected    <= 1'b0;
    end else begin
      word_loaded   <= 1'b0;
      word_rejected <= 1'b0;
      if (three_wire_mode && ena_fall) begin
        if (count_ok) begin
          // Bit 14 forced zero; binary weights
          scaling_factor   <= {1'b0, div_word};
          // Port bits only reach port_output_bits; port1_oe stays off
          port_output_bits <= port_word;
          word_loaded      <= 1'b1;
        end else begin
          word_rejected <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Forced loop settings and reference ratio
  // ----------------------------------------------------------------
  wire [10:0] ratio_dec;

  tpwl_ref_decode u_ref (
    .ref_sel_low  (ref_ratio_sel_low),
    .ref_sel_high (ref_ratio_sel_high),
    .ratio        (ratio_dec)
  );

  // Registered copies of fixed settings and lock pin drive
  always @(posedge sys_clk) begin
    if (!resetn) begin
      ref_ratio             <= `TPWL_RATIO_MID;
      pump_current_high     <= `TPWL_PUMP_HIGH;
      divider_test_select   <= `TPWL_TEST_OFF;
      pump_disable_bit      <= `TPWL_PUMP_ON;
      prescaler_on          <= `TPWL_PSC_ON;
      varicap_drive_off     <= `TPWL_VARICAP_ON;
      pll_enable            <= 1'b0;
      lock_indicator_pin_oe <= 1'b0;
      port1_oe              <= 1'b0;
    end else begin
      ref_ratio           <= ratio_dec;
      pump_current_high   <= `TPWL_PUMP_HIGH;
      divider_test_select <= `TPWL_TEST_OFF;
      pump_disable_bit    <= `TPWL_PUMP_ON;
      prescaler_on        <= `TPWL_PSC_ON;
      varicap_drive_off   <= `TPWL_VARICAP_ON;
      pll_enable          <= (scaling_factor != 15'h0000);
      // Lock pin pulls low when locked in three-wire mode
      lock_indicator_pin_oe <= three_wire_mode & lock_detect;
      port1_oe              <= 1'b0;
    end
  end
endmodule

// >>> bench/tpwl_ctrl_model.sv
// Controller model: drives data, clock and enable of the three-wire link.
// Assumes the bench calls send and waits for it to return.
`timescale 1ns/100ps
module tpwl_ctrl_model (
  output logic data,
  output logic sclk,
  output logic ena
);
  initial begin
    data = 1'b0;
    sclk = 1'b0;
    ena  = 1'b0;
  end
  // Clock period 125 ns; data moves mid-low so it is stable at each fall
  task automatic send(input logic [17:0] w, input int n, input int pre);
    int i;
    for (i = 0; i < pre; i++) begin
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
    end
    // enable, MSB-first bits, enable low
    // Gap after stray clocks so their last fall never meets the enable rise
    #62.5 ena = 1'b1;
    for (i = 0; i < n; i++) begin
      #31 data = w[17 - (i % 18)];
      #31.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
    end
    #62.5 ena = 1'b0;
    data = ~data; // Released line shows no stale bit
    #10000;
  endtask
endmodule

// >>> bench/tpwl_assertions.sv
// Checker of the loader's port behaviour.
// Assumes binding to tpwl_loader; ratio constants come from the defines.
`timescale 1ns/100ps
`include "tpwl_defs.vh"
module tpwl_assertions (
  input wire        sys_clk,
  input wire        resetn,
  input wire        three_wire_mode,
  input wire        ref_ratio_sel_low,
  input wire        ref_ratio_sel_high,
  input wire        lock_detect,
  input wire [14:0] scaling_factor,
  input wire        lock_indicator_pin_oe,
  input wire        port1_oe,
  input wire [10:0] ref_ratio,
  input wire        pump_current_high,
  input wire        divider_test_select,
  input wire        pump_disable_bit,
  input wire        prescaler_on,
  input wire        varicap_drive_off,
  input wire        pll_enable,
  input wire        word_loaded,
  input wire        word_rejected
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_msb_zero: assert property (scaling_factor[14] == 1'b0)
    else $error("divider top bit set");
  a_fixed_ctl: assert property (three_wire_mode |->
    pump_current_high && prescaler_on && !divider_test_select && !pump_disable_bit
    && !varicap_drive_off) else $error("fixed bit wrong");
  a_hold_latch: assert property ($changed(scaling_factor) |-> word_loaded)
    else $error("divider changed without load");
  a_lock_follow: assert property ($past(resetn) |->
    lock_indicator_pin_oe == $past(three_wire_mode && lock_detect)) else $error("lock output wrong");
  a_port1_off: assert property (three_wire_mode |-> !port1_oe)
    else $error("port one driven");
  a_ref_pick: assert property ($past(resetn) |-> ref_ratio == ($past(ref_ratio_sel_low) ?
    `TPWL_RATIO_LOW : $past(ref_ratio_sel_high) ? `TPWL_RATIO_HIGH : `TPWL_RATIO_MID))
    else $error("ratio wrong");
  a_pll_off: assert property ($past(resetn) |->
    pll_enable == ($past(scaling_factor) != 15'h0000)) else $error("loop enable wrong");
  a_pulse_one: assert property (word_loaded |-> !word_rejected ##1 !word_loaded)
    else $error("load pulse wrong");
  a_mode_quiet: assert property ((!three_wire_mode) [*8] |-> !word_loaded && !word_rejected)
    else $error("pulse with mode off");
  c_load: cover property (word_loaded);
  c_rej: cover property (word_rejected);
  c_lock: cover property ($rose(lock_indicator_pin_oe));
endmodule
bind tpwl_loader tpwl_assertions chk_u (.sys_clk(sys_clk), .resetn(resetn),
  .three_wire_mode(three_wire_mode), .ref_ratio_sel_low(ref_ratio_sel_low),
  .ref_ratio_sel_high(ref_ratio_sel_high), .lock_detect(lock_detect),
  .scaling_factor(scaling_factor), .lock_indicator_pin_oe(lock_indicator_pin_oe),
  .port1_oe(port1_oe), .ref_ratio(ref_ratio), .pump_current_high(pump_current_high),
  .divider_test_select(divider_test_select), .pump_disable_bit(pump_disable_bit),
  .prescaler_on(prescaler_on), .varicap_drive_off(varicap_drive_off),
  .pll_enable(pll_enable), .word_loaded(word_loaded), .word_rejected(word_rejected));

// >>> bench/tb_top.sv
// Self-checking bench of the three-wire loader.
// Assumes the controller model and the bound checker.
`timescale 1ns/100ps
module tb_top;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        mode = 1'b1;
  logic        lsel = 1'b0;
  logic        hsel = 1'b0;
  logic        lock = 1'b0;
  logic        sd, sc, se;
  logic [14:0] sf;
  logic [3:0]  pt;
  logic [10:0] ratio;
  logic        oe, pll, ld, rj;
  int bad_count, n_checks, n_load, n_rej, cyc, k, seed, exp_sf, exp_pt;
  always #5 sys_clk = ~sys_clk;
  tpwl_ctrl_model ctrl_u (.data(sd), .sclk(sc), .ena(se));
  tpwl_loader dut_u (.sys_clk(sys_clk), .resetn(resetn), .serial_data_in(sd),
    .serial_clk_in(sc), .select_enable_pin(se), .three_wire_mode(mode),
    .ref_ratio_sel_low(lsel), .ref_ratio_sel_high(hsel), .lock_detect(lock),
    .scaling_factor(sf), .port_output_bits(pt), .lock_indicator_pin_oe(oe), .port1_oe(),
    .ref_ratio(ratio), .pump_current_high(), .divider_test_select(), .pump_disable_bit(),
    .prescaler_on(), .varicap_drive_off(), .pll_enable(pll), .word_loaded(ld),
    .word_rejected(rj));
  // Pulse counting and hang limit
  always @(posedge sys_clk) begin
    n_load += (ld === 1'b1);
    n_rej += (rj === 1'b1);
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // One transfer, then compare against the reference model
  task automatic frame(input logic [17:0] w, input int n, input int pre);
    int l0, r0, ok;
    l0 = n_load;
    r0 = n_rej;
    ok = mode && n == 18;
    ctrl_u.send(w, n, pre);
    tick(1);
    if (ok) begin
      exp_sf = w[17:4];
      exp_pt = w[3:0];
    end
    chk("word_loaded", ok, n_load - l0);
    chk("word_rejected", mode && !ok, n_rej - r0);
    chk("scaling_factor", exp_sf, sf);
    chk("port_output_bits", exp_pt, pt);
    chk("pll_enable", exp_sf != 0, pll);
  endtask
  initial begin
    seed = 43;
    tick(4);
    resetn = 1'b1;
    tick(6);
    chk("ref_ratio", 32'h200, ratio);
    for (k = 0; k < 6; k++) frame($random(seed), 18, k % 3);
    frame(18'h0, 18, 0);
    frame($random(seed), 17, 0);
    frame($random(seed), 19, 1);
    frame($random(seed), 50, 2);
    frame($random(seed), 18, 0);
    for (k = 0; k < 4; k++) begin
      {lsel, hsel} = 2'(k);
      tick(3);
      chk("ref_ratio", lsel ? 32'h400 : hsel ? 32'h280 : 32'h200, ratio);
    end
    for (k = 0; k < 4; k++) begin
      {mode, lock} = 2'(k ^ 3);
      lock = lock ^ 1'($random(seed));
      tick(3);
      chk("lock_oe", mode && lock, oe);
    end
    frame($random(seed), 18, 0);
    give_verdict();
  end
endmodule
